/* File: cpuasx_core.sv */
// Execution datapath for subtract, swap, exclusive-OR and direction-load
// Notes on behaviour
// RULE1 - Subtract: file minus accumulator, two's complement
// RULE2 - Destination bit 0 to accumulator, 1 to file
// RULE3 - Subtracts set carry, digit carry and zero
// RULE4 - Borrow subtract also removes inverted carry
// RULE5 - Swap exchanges nibbles, flags untouched
// RULE6 - Immediate XOR writes accumulator, zero flag only
// RULE7 - Direction load: operand 5,6,7 picks port
// RULE8 - File XOR routed by destination, zero only
// RULE9 - Zero flag tracks eight-bit result; 7-bit address
`timescale 1ns/1ps
`include "cpuasx_params.svh"
module cpuasx_core
(
    input  wire logic                i_clk,            // Core clock
    input  wire logic                i_arst_n,         // Asynchronous reset
    // Decoder side
    input  wire logic                i_op_valid,       // Instruction present
    input  wire cpuasx_pkg::cpuasx_op_e i_opcode,      // Instruction code
    input  wire logic [6:0]          i_file_addr,      // File address or port select
    input  wire logic [7:0]          i_literal,        // Immediate operand
    input  wire logic                i_dest,           // Destination bit
    input  wire logic [7:0]          i_file_data,      // Addressed file value
    // Register file write-back
    output logic                     o_file_we,        // File write strobe
    output logic [6:0]               o_file_addr,      // File write address
    output logic [7:0]               o_file_wdata,     // File write data
    // Port direction registers
    output logic [7:0]               o_port_a_direction,
    output logic [7:0]               o_port_b_direction,
    output logic [7:0]               o_port_c_direction,
    // AXI4-Lite slave
    input  wire logic [7:0]          i_s_axi_awaddr,
    input  wire logic                i_s_axi_awvalid,
    output logic                     o_s_axi_awready,
    input  wire logic [31:0]         i_s_axi_wdata,
    input  wire logic [3:0]          i_s_axi_wstrb,
    input  wire logic                i_s_axi_wvalid,
    output logic                     o_s_axi_wready,
    output logic [1:0]               o_s_axi_bresp,
    output logic                     o_s_axi_bvalid,
    input  wire logic                i_s_axi_bready,
    input  wire logic [7:0]          i_s_axi_araddr,
    input  wire logic                i_s_axi_arvalid,
    output logic                     o_s_axi_arready,
    output logic [31:0]              o_s_axi_rdata,
    output logic [1:0]               o_s_axi_rresp,
    output logic                     o_s_axi_rvalid,
    input  wire logic                i_s_axi_rready
);
    import cpuasx_pkg::*;
    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    // Zero test of an eight-bit result
    function automatic logic is_zero(input logic [7:0] value);
        is_zero = (value == 8'h00); // RULE9
    endfunction : is_zero
    // Register select: true when an address names a given offset
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = ({addr[7:2], 2'b00} == ofs);
    endfunction : hit
    // True when an address falls on any mapped register
    function automatic logic mapped(input logic [7:0] addr);
        mapped = ({addr[7:2], 2'b00} <= `CPUASX_OFS_RESULT);
    endfunction : mapped
    // ----------------------------------------
    // State
    // ----------------------------------------
    cpuasx_byte_t acc;          // Working accumulator
    logic [2:0]   status;       // Zero, digit carry, carry
    cpuasx_byte_t last_result;  // Last datapath result
    logic [7:0]   aw_addr;      // Held write address
    logic         aw_held;      // Write address taken
    logic [7:0]   w_data;       // Held write byte
    logic         w_lane0;      // Low byte lane enabled
    logic         w_held;       // Write data taken
    // ----------------------------------------
    // Subtractor
    // ----------------------------------------
    logic         sub_carry_in; // Carry in, 1 for plain subtract
    logic [7:0]   sub_diff;
    logic         sub_carry;
    logic         sub_dcarry;
    assign sub_carry_in = (i_opcode == CPUASX_OP_SUB_ACC_FROM_FILE_BORROW)
                        ? status[`CPUASX_ST_CARRY] : 1'b1; // RULE4
    cpuasx_sub u_sub
    (
        .i_minuend    (i_file_data),
        .i_subtrahend (acc),
        .i_carry_in   (sub_carry_in),
        .o_diff       (sub_diff),
        .o_carry      (sub_carry),
        .o_dcarry     (sub_dcarry)
    );
    // ----------------------------------------
    // Instruction decode
    // ----------------------------------------
    wire op_sub   = i_op_valid && ((i_opcode == CPUASX_OP_SUB_ACC_FROM_FILE)
                  || (i_opcode == CPUASX_OP_SUB_ACC_FROM_FILE_BORROW));
    wire op_swap  = i_op_valid && (i_opcode == CPUASX_OP_NIBBLE_EXCHANGE);
    wire op_xori  = i_op_valid && (i_opcode == CPUASX_OP_XOR_IMMEDIATE);
    wire op_xorf  = i_op_valid && (i_opcode == CPUASX_OP_XOR_FILE_OPERAND);
    wire op_dir   = i_op_valid && (i_opcode == CPUASX_OP_DIRECTION_LOAD);
    wire op_route = op_sub || op_swap || op_xorf; // Destination-bit users
    // Result selection
    wire [7:0] swap_val = {i_file_data[3:0], i_file_data[7:4]}; // RULE5
    wire [7:0] xori_val = acc ^ i_literal;                        // RULE6
    wire [7:0] xorf_val = acc ^ i_file_data;                      // RULE8
    wire [7:0] result   = op_sub  ? sub_diff                      // RULE1
                        : op_swap ? swap_val
                        : op_xori ? xori_val
                        : xorf_val;
    // Destination steering
    wire acc_from_op  = op_xori || (op_route && !i_dest);         // RULE2
    wire file_from_op = op_route && i_dest;                       // RULE2
    // Flag update
    logic [2:0] next_flags;    // Status after the instruction
    wire        flags_from_op = op_sub || op_xori || op_xorf;
    always_comb
    begin
        next_flags = status;
        if (op_sub)
        begin
            next_flags[`CPUASX_ST_CARRY]  = sub_carry;            // RULE3
            next_flags[`CPUASX_ST_DCARRY] = sub_dcarry;           // RULE3
        end
        next_flags[`CPUASX_ST_ZERO] = is_zero(result);            // RULE9
    end
    // Direction-load port select
    wire dir_a = op_dir && (i_file_addr == `CPUASX_SEL_PORT_A);   // RULE7
    wire dir_b = op_dir && (i_file_addr == `CPUASX_SEL_PORT_B);   // RULE7
    wire dir_c = op_dir && (i_file_addr == `CPUASX_SEL_PORT_C);   // RULE7
    // ----------------------------------------
    // AXI write decode
    // ----------------------------------------
    assign o_s_axi_awready = !aw_held && !o_s_axi_bvalid;
    assign o_s_axi_wready  = !w_held && !o_s_axi_bvalid;
    wire   wr_go     = aw_held && w_held && !o_s_axi_bvalid;
    wire   wr_en     = wr_go && w_lane0;
    wire   wr_acc    = wr_en && hit(aw_addr, `CPUASX_OFS_ACC);
    wire   wr_status = wr_en && hit(aw_addr, `CPUASX_OFS_STATUS);
    wire   wr_dir_a  = wr_en && hit(aw_addr, `CPUASX_OFS_DIR_A);
    wire   wr_dir_b  = wr_en && hit(aw_addr, `CPUASX_OFS_DIR_B);
    wire   wr_dir_c  = wr_en && hit(aw_addr, `CPUASX_OFS_DIR_C);
    wire   wr_mapped = mapped(aw_addr);
    // ----------------------------------------
    // AXI read decode
    // ----------------------------------------
    assign o_s_axi_arready = !o_s_axi_rvalid;
    wire        rd_go = i_s_axi_arvalid && o_s_axi_arready;
    logic [7:0] rd_byte;   // Selected register
    wire        rd_ok = mapped(i_s_axi_araddr); // Address is mapped
    always_comb
    begin
        rd_byte = 8'h00;
        if (hit(i_s_axi_araddr, `CPUASX_OFS_ACC))
            rd_byte = acc;
        else if (hit(i_s_axi_araddr, `CPUASX_OFS_STATUS))
            rd_byte = {5'h00, status};
        else if (hit(i_s_axi_araddr, `CPUASX_OFS_DIR_A))
            rd_byte = o_port_a_direction;
        else if (hit(i_s_axi_araddr, `CPUASX_OFS_DIR_B))
            rd_byte = o_port_b_direction;
        else if (hit(i_s_axi_araddr, `CPUASX_OFS_DIR_C))
            rd_byte = o_port_c_direction;
        else if (hit(i_s_axi_araddr, `CPUASX_OFS_RESULT))
            rd_byte = last_result;
    end
    // ----------------------------------------
    // Accumulator and status; instruction wins over bus write
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            acc    <= `CPUASX_RST_ACC;
            status <= `CPUASX_RST_STATUS;
        end
        else
        begin
            if (acc_from_op)
                acc <= result;                                     // RULE2
            else if (wr_acc)
                acc <= w_data;
            if (flags_from_op)
                status <= next_flags;                              // RULE3
            else if (wr_status)
                status <= w_data[2:0];
        end
    end
    // ----------------------------------------
    // Direction registers; instruction wins over bus write
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_port_a_direction <= `CPUASX_RST_DIR;
            o_port_b_direction <= `CPUASX_RST_DIR;
            o_port_c_direction <= `CPUASX_RST_DIR;
        end
        else
        begin
            if (dir_a || wr_dir_a)
                o_port_a_direction <= dir_a ? acc : w_data;        // RULE7
            if (dir_b || wr_dir_b)
                o_port_b_direction <= dir_b ? acc : w_data;        // RULE7
            if (dir_c || wr_dir_c)
                o_port_c_direction <= dir_c ? acc : w_data;        // RULE7
        end
    end
    // ----------------------------------------
    // File write-back, one cycle after the instruction
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_file_we    <= 1'b0;
            o_file_addr  <= 7'h00;
            o_file_wdata <= 8'h00;
            last_result  <= 8'h00;
        end
        else
        begin
            o_file_we <= file_from_op;                             // RULE2
            if (file_from_op)
            begin
                o_file_addr  <= i_file_addr;                       // RULE9
                o_file_wdata <= result;
            end
            if (acc_from_op || file_from_op)
                last_result <= result;
        end
    end
    // ----------------------------------------
    // AXI write channel
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            aw_held        <= 1'b0;
            aw_addr        <= 8'h00;
            w_held         <= 1'b0;
            w_data         <= 8'h00;
            w_lane0        <= 1'b0;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp  <= `CPUASX_RESP_OKAY;
        end
        else
        begin
            if (i_s_axi_awvalid && o_s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= i_s_axi_awaddr;
            end
            if (i_s_axi_wvalid && o_s_axi_wready)
            begin
                w_held  <= 1'b1;
                w_data  <= i_s_axi_wdata[7:0];
                w_lane0 <= i_s_axi_wstrb[0];
            end
            if (wr_go)
            begin
                aw_held        <= 1'b0;
                w_held         <= 1'b0;
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp  <= wr_mapped ? `CPUASX_RESP_OKAY : `CPUASX_RESP_SLVERR;
            end
            else if (o_s_axi_bvalid && i_s_axi_bready)
                o_s_axi_bvalid <= 1'b0;
        end
    end
    // ----------------------------------------
    // AXI read channel
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata  <= 32'h0000_0000;
            o_s_axi_rresp  <= `CPUASX_RESP_OKAY;
        end
        else if (rd_go)
        begin
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rdata  <= {24'h00_0000, rd_byte};
            o_s_axi_rresp  <= rd_ok ? `CPUASX_RESP_OKAY : `CPUASX_RESP_SLVERR;
        end
        else if (o_s_axi_rvalid && i_s_axi_rready)
            o_s_axi_rvalid <= 1'b0;
    end
endmodule : cpuasx_core

/* File: cpuasx_core_asserts.sv */
// Port-level checks for the subtract, swap and exclusive-OR datapath
`timescale 1ns/1ps
`include "cpuasx_params.svh"
module cpuasx_core_asserts
(
    input wire logic       i_clk,
    input wire logic       i_arst_n,
    input wire logic       i_op_valid,
    input wire logic [2:0] i_opcode,
    input wire logic [6:0] i_file_addr,
    input wire logic       i_dest,
    input wire logic [7:0] i_file_data,
    input wire logic       o_file_we,
    input wire logic [6:0] o_file_addr,
    input wire logic [7:0] o_file_wdata,
    input wire logic [7:0] o_port_b_direction,
    input wire logic [7:0] o_port_c_direction,
    input wire logic       i_s_axi_awvalid,
    input wire logic       i_s_axi_wvalid,
    input wire logic       i_s_axi_bready,
    input wire logic       o_s_axi_bvalid,
    input wire logic       i_s_axi_arvalid,
    input wire logic       o_s_axi_arready,
    input wire logic       i_s_axi_rready,
    input wire logic       o_s_axi_rvalid
);
    import cpuasx_pkg::*;
    // Instruction whose result goes back to the file
    wire wb_req = i_op_valid && i_dest && (i_opcode inside {CPUASX_OP_SUB_ACC_FROM_FILE,
        CPUASX_OP_SUB_ACC_FROM_FILE_BORROW, CPUASX_OP_NIBBLE_EXCHANGE, CPUASX_OP_XOR_FILE_OPERAND});
    // Direction load present
    wire dir_ld = i_op_valid && (i_opcode == CPUASX_OP_DIRECTION_LOAD);
    // Bus write offered last cycle; a late register update could look like a fault
    logic bus_prev;
    always_ff @(posedge i_clk or negedge i_arst_n)
        if (!i_arst_n) bus_prev <= 1'b0;
        else bus_prev <= i_s_axi_awvalid || i_s_axi_wvalid;
    wire quiet = !bus_prev && !i_s_axi_awvalid && !i_s_axi_wvalid;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    a_we_cause: assert property (o_file_we |-> $past(wb_req))
        else $error("file write without a write-back instruction");
    a_we_pulse: assert property (wb_req |=> o_file_we)
        else $error("file write missing");
    a_we_addr: assert property (wb_req |=> o_file_addr == $past(i_file_addr))
        else $error("file write address differs");
    a_swap_data: assert property (wb_req && i_opcode == CPUASX_OP_NIBBLE_EXCHANGE
        |=> o_file_wdata == {$past(i_file_data[3:0]), $past(i_file_data[7:4])})
        else $error("nibble exchange data wrong");
    a_wdata_hold: assert property (!o_file_we |-> $stable(o_file_wdata))
        else $error("file data moved without a write");
    a_dir_select: assert property (dir_ld && quiet && i_file_addr == `CPUASX_SEL_PORT_A
        |=> $stable(o_port_b_direction) && $stable(o_port_c_direction))
        else $error("wrong direction register loaded");
    a_dir_refuse: assert property (dir_ld && quiet && i_file_addr > `CPUASX_SEL_PORT_C
        |=> $stable(o_port_c_direction) [*2])
        else $error("direction changed on bad select");
    a_write_done: assert property (o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid)
        else $error("write response not retired");
    a_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
        else $error("read answer late");
    a_read_done: assert property (o_s_axi_rvalid && i_s_axi_rready
        |=> !o_s_axi_rvalid && o_s_axi_arready)
        else $error("read response not retired");
endmodule : cpuasx_core_asserts
bind cpuasx_core cpuasx_core_asserts u_asserts (.*);

/* File: cpuasx_params.svh */
// Constants for the subtract, swap and exclusive-OR datapath
`ifndef CPUASX_PARAMS_SVH
`define CPUASX_PARAMS_SVH

// ----------------------------------------
// Register byte offsets on the AXI4-Lite bus
// ----------------------------------------
`define CPUASX_OFS_ACC      8'h00
`define CPUASX_OFS_STATUS   8'h04
`define CPUASX_OFS_DIR_A    8'h08
`define CPUASX_OFS_DIR_B    8'h0c
`define CPUASX_OFS_DIR_C    8'h10
`define CPUASX_OFS_RESULT   8'h14

// ----------------------------------------
// Status field positions
// ----------------------------------------
`define CPUASX_ST_CARRY     0
`define CPUASX_ST_DCARRY    1
`define CPUASX_ST_ZERO      2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CPUASX_RST_ACC      8'h00
`define CPUASX_RST_STATUS   3'h0
`define CPUASX_RST_DIR      8'hff

// ----------------------------------------
// Direction-load operand selections
// ----------------------------------------
`define CPUASX_SEL_PORT_A   7'h05
`define CPUASX_SEL_PORT_B   7'h06
`define CPUASX_SEL_PORT_C   7'h07

// ----------------------------------------
// AXI responses
// ----------------------------------------
`define CPUASX_RESP_OKAY    2'h0
`define CPUASX_RESP_SLVERR  2'h2

`endif

/* File: cpuasx_pkg.sv */
// Types shared by the datapath files
package cpuasx_pkg;

    // Instruction codes delivered by the decoder
    typedef enum logic [2:0]
    {
        CPUASX_OP_NONE                     = 3'h0,
        CPUASX_OP_SUB_ACC_FROM_FILE        = 3'h1,
        CPUASX_OP_SUB_ACC_FROM_FILE_BORROW = 3'h2,
        CPUASX_OP_NIBBLE_EXCHANGE          = 3'h3,
        CPUASX_OP_XOR_IMMEDIATE            = 3'h4,
        CPUASX_OP_XOR_FILE_OPERAND         = 3'h5,
        CPUASX_OP_DIRECTION_LOAD           = 3'h6
    } cpuasx_op_e;

    typedef logic [7:0] cpuasx_byte_t;

endpackage : cpuasx_pkg

/* File: cpuasx_regfile_model.sv */
// Data memory model that feeds and absorbs file operands
`timescale 1ns/1ps
module cpuasx_regfile_model
(
    input  wire logic       i_clk,
    input  wire logic       i_we,
    input  wire logic [6:0] i_waddr,
    input  wire logic [7:0] i_wdata,
    input  wire logic [6:0] i_raddr,
    output logic      [7:0] o_rdata
);
    logic [7:0] mem [128];
    // Known pattern so every address holds a distinct value
    initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 17);
    // Operand is ready in the same cycle as its address
    assign o_rdata = mem[i_raddr];
    // Write-back lands on the strobe edge
    always @(posedge i_clk) if (i_we) mem[i_waddr] <= i_wdata;
endmodule : cpuasx_regfile_model

/* File: cpuasx_sub.sv */
// Eight-bit subtractor with carry and digit carry out
`timescale 1ns/1ps
module cpuasx_sub
(
    input  wire logic [7:0] i_minuend,     // File operand
    input  wire logic [7:0] i_subtrahend,  // Accumulator
    input  wire logic       i_carry_in,    // Carry flag on borrow subtract, else 1; active-low borrow
    output logic      [7:0] o_diff,        // Difference
    output logic            o_carry,       // 1 when no borrow out of bit 7
    output logic            o_dcarry       // 1 when no borrow out of bit 3
);
    // ----------------------------------------
    // Two's complement add of the inverted subtrahend
    // ----------------------------------------
    logic [4:0] low_sum;   // Low nibble sum with carry
    logic [4:0] high_sum;  // High nibble sum with carry

    assign low_sum  = {1'b0, i_minuend[3:0]} + {1'b0, ~i_subtrahend[3:0]}
                    + {4'h0, i_carry_in};
    assign high_sum = {1'b0, i_minuend[7:4]} + {1'b0, ~i_subtrahend[7:4]}
                    + {4'h0, low_sum[4]};
    assign o_diff   = {high_sum[3:0], low_sum[3:0]};
    assign o_carry  = high_sum[4];
    assign o_dcarry = low_sum[4];
endmodule : cpuasx_sub

/* File: tb.sv */
// Self-checking bench for the subtract, swap and exclusive-OR datapath
`timescale 1ns/1ps
`include "cpuasx_params.svh"
module tb;
    import cpuasx_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        clk, arst_n, op_valid, dest, we, awv, awr, wv, wr, bv, br, arv, arr, rv, rr_o;
    cpuasx_op_e  opcode;
    logic [6:0]  faddr, waddr;
    logic [7:0]  lit, fdata, wdat, dir_a, dir_b, dir_c, awa, ara;
    logic [31:0] wd, rdat;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    int          error_cnt, checks_done;
    cpuasx_core dut (.i_clk(clk), .i_arst_n(arst_n), .i_op_valid(op_valid), .i_opcode(opcode),
        .i_file_addr(faddr), .i_literal(lit), .i_dest(dest), .i_file_data(fdata),
        .o_file_we(we), .o_file_addr(waddr), .o_file_wdata(wdat), .o_port_a_direction(dir_a),
        .o_port_b_direction(dir_b), .o_port_c_direction(dir_c), .i_s_axi_awaddr(awa),
        .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(wstrb),
        .i_s_axi_wvalid(wv), .o_s_axi_wready(wr), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv),
        .i_s_axi_bready(br), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
        .o_s_axi_rdata(rdat), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rv), .i_s_axi_rready(rr_o));
    cpuasx_regfile_model rf (.i_clk(clk), .i_we(we), .i_waddr(waddr), .i_wdata(wdat),
        .i_raddr(faddr), .o_rdata(fdata));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ----------------------------------------
    // Report and compare
    // ----------------------------------------
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk32
    // ----------------------------------------
    // Bus and instruction drivers
    // ----------------------------------------
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        awa <= a; awv <= 1'b1; wd <= d; wv <= 1'b1; br <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
        end
        while (!(bv && br) && n < 100);
        r = bresp;
        br <= 1'b0;
        if (!bv)
        begin
            error_cnt++;
            end_of_test();
        end
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        ara <= a; arv <= 1'b1; rr_o <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
            if (arv && arr) arv <= 1'b0;
        end
        while (!(rv && rr_o) && n < 100);
        d = rdat;
        r = rresp;
        rr_o <= 1'b0;
        if (!rv)
        begin
            error_cnt++;
            end_of_test();
        end
    endtask : axi_rd
    task automatic issue(input cpuasx_op_e op, input logic [6:0] a, input logic [7:0] k,
                         input logic d);
        @(posedge clk);
        op_valid <= 1'b1; opcode <= op; faddr <= a; lit <= k; dest <= d;
    endtask : issue
    task automatic idle();
        @(posedge clk);
        op_valid <= 1'b0;
    endtask : idle
    // Expected {result, status} from accumulator w, status s, file f, immediate k
    function automatic logic [10:0] model(cpuasx_op_e op, logic [7:0] w, logic [2:0] s,
                                          logic [7:0] f, logic [7:0] k);
        logic       b;
        logic [8:0] d;
        logic [4:0] l;
        logic [7:0] r;
        b = (op == CPUASX_OP_SUB_ACC_FROM_FILE_BORROW) ? !s[`CPUASX_ST_CARRY] : 1'b0;
        d = {1'b0, f} - {1'b0, w} - 9'(b);
        l = {1'b0, f[3:0]} - {1'b0, w[3:0]} - 5'(b);
        r = w;
        case (op)
            CPUASX_OP_SUB_ACC_FROM_FILE, CPUASX_OP_SUB_ACC_FROM_FILE_BORROW:
            begin
                r = d[7:0];
                s[`CPUASX_ST_CARRY] = !d[8];
                s[`CPUASX_ST_DCARRY] = !l[4];
            end
            CPUASX_OP_NIBBLE_EXCHANGE: r = {f[3:0], f[7:4]};
            CPUASX_OP_XOR_IMMEDIATE: r = w ^ k;
            CPUASX_OP_XOR_FILE_OPERAND: r = w ^ f;
            default: r = w;
        endcase
        if (op inside {[1:2], [4:5]}) s[`CPUASX_ST_ZERO] = (r == 8'h00);
        return {r, s};
    endfunction : model
    // Load state, run one instruction, check results
    task automatic run_case(input cpuasx_op_e op, input logic [6:0] a, input logic [7:0] k,
                            input logic d, input logic [7:0] w, input logic [2:0] s);
        logic [7:0]  f;
        logic [10:0] m;
        logic [31:0] rd;
        logic [1:0]  rs;
        logic        wf;
        f = rf.mem[a];
        m = model(op, w, s, f, k);
        wf = d && (op inside {[1:3], 5});
        axi_wr(`CPUASX_OFS_ACC, {24'h0, w}, rs);
        axi_wr(`CPUASX_OFS_STATUS, {29'h0, s}, rs);
        issue(op, a, k, d);
        idle();
        axi_rd(`CPUASX_OFS_ACC, rd, rs);
        chk32(rd, {24'h0, wf ? w : m[10:3]});
        axi_rd(`CPUASX_OFS_STATUS, rd, rs);
        chk32(rd, {29'h0, m[2:0]});
        chk32({24'h0, rf.mem[a]}, {24'h0, wf ? m[10:3] : f});
    endtask : run_case
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        logic [31:0] rd;
        logic [1:0]  rs;
        error_cnt = 0; checks_done = 0; arst_n = 1'b0; op_valid = 1'b0; dest = 1'b0;
        opcode = CPUASX_OP_NONE; faddr = 7'h00; lit = 8'h00; awa = 8'h00; awv = 1'b0;
        wd = 32'h0; wstrb = 4'hf; wv = 1'b0; br = 1'b0; ara = 8'h00; arv = 1'b0; rr_o = 1'b0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        wstrb <= 4'h0;
        axi_wr(`CPUASX_OFS_ACC, 32'hff, rs);
        wstrb <= 4'hf;
        axi_rd(`CPUASX_OFS_ACC, rd, rs);
        chk32(rd, 32'h0);
        axi_wr(8'h18, 32'h0, rs);
        chk32({30'h0, rs}, {30'h0, `CPUASX_RESP_SLVERR});
        axi_rd(`CPUASX_OFS_STATUS, rd, rs);
        chk32(rd, 32'h0);
        axi_rd(8'h18, rd, rs);
        chk32({30'h0, rs}, {30'h0, `CPUASX_RESP_SLVERR});
        run_case(CPUASX_OP_SUB_ACC_FROM_FILE, 7'h03, 8'h00, 1'b0, 8'h33, 3'h0);
        run_case(CPUASX_OP_SUB_ACC_FROM_FILE, 7'h02, 8'h00, 1'b1, 8'h05, 3'h4);
        run_case(CPUASX_OP_SUB_ACC_FROM_FILE, 7'h01, 8'h00, 1'b0, 8'h12, 3'h7);
        run_case(CPUASX_OP_SUB_ACC_FROM_FILE, 7'h7f, 8'h00, 1'b1, 8'h6f, 3'h0);
        run_case(CPUASX_OP_SUB_ACC_FROM_FILE_BORROW, 7'h04, 8'h00, 1'b0, 8'h44, 3'h6);
        run_case(CPUASX_OP_SUB_ACC_FROM_FILE_BORROW, 7'h05, 8'h00, 1'b1, 8'h15, 3'h1);
        run_case(CPUASX_OP_NIBBLE_EXCHANGE, 7'h12, 8'h00, 1'b0, 8'h77, 3'h7);
        run_case(CPUASX_OP_NIBBLE_EXCHANGE, 7'h13, 8'h00, 1'b1, 8'h77, 3'h2);
        run_case(CPUASX_OP_XOR_IMMEDIATE, 7'h08, 8'ha5, 1'b1, 8'ha5, 3'h3);
        run_case(CPUASX_OP_XOR_IMMEDIATE, 7'h08, 8'hff, 1'b0, 8'h0f, 3'h4);
        run_case(CPUASX_OP_XOR_FILE_OPERAND, 7'h06, 8'h00, 1'b1, 8'h66, 3'h0);
        run_case(CPUASX_OP_XOR_FILE_OPERAND, 7'h07, 8'h00, 1'b0, 8'h01, 3'h5);
        run_case(CPUASX_OP_NONE, 7'h09, 8'h00, 1'b1, 8'h5a, 3'h7);
        // Back-to-back subtract then borrow subtract chains the carry
        axi_wr(`CPUASX_OFS_ACC, 32'h1, rs);
        axi_wr(`CPUASX_OFS_STATUS, 32'h1, rs);
        issue(CPUASX_OP_SUB_ACC_FROM_FILE, 7'h00, 8'h00, 1'b0);
        issue(CPUASX_OP_SUB_ACC_FROM_FILE_BORROW, 7'h00, 8'h00, 1'b0);
        idle();
        axi_rd(`CPUASX_OFS_ACC, rd, rs);
        chk32(rd, 32'h0);
        axi_rd(`CPUASX_OFS_STATUS, rd, rs);
        chk32(rd, 32'h4);
        // Direction loads over selects 4 to 8; only 5, 6 and 7 land
        axi_wr(`CPUASX_OFS_STATUS, 32'h7, rs);
        for (int s = 4; s <= 8; s++)
        begin
            axi_wr(`CPUASX_OFS_ACC, 32'(8'h30 + s), rs);
            issue(CPUASX_OP_DIRECTION_LOAD, 7'(s), 8'h00, 1'b0);
            idle();
        end
        chk32({dir_a, dir_b, dir_c, 8'h0}, 32'h35363700);
        axi_rd(`CPUASX_OFS_DIR_C, rd, rs);
        chk32(rd, 32'h37);
        axi_rd(`CPUASX_OFS_STATUS, rd, rs);
        chk32(rd, 32'h7);
        end_of_test();
    end
endmodule : tb
